//--- rtl/fswc_pkg.sv
// Purpose: shared constants for the settings write command decoder
// Assumes: reports arrive as 64 bytes, byte 0 first
// Notes: status codes are fixed package constants, not module parameters
package fswc_pkg;
  // report framing
  localparam int RPT_LEN = 64;
  localparam logic [5:0] IDX_CMD = 6'h00;
  localparam logic [5:0] IDX_SUB = 6'h01;
  localparam logic [5:0] IDX_PAY_FIRST = 6'h02;
  localparam logic [5:0] IDX_LAST = 6'h3F;
  localparam logic [5:0] IDX_CHIP_LAST = 6'h13;
  localparam int CHIP_BYTES = 18;
  // command and sub-codes
  localparam logic [7:0] CMD_WRITE_NV = 8'hB1;
  localparam logic [7:0] SUB_CHIP = 8'h00;
  localparam logic [7:0] SUB_GENPIN = 8'h01;
  localparam logic [7:0] SUB_STR_MFR = 8'h02;
  localparam logic [7:0] SUB_STR_PROD = 8'h03;
  localparam logic [7:0] SUB_STR_SER = 8'h04;
  // response status codes
  localparam logic [7:0] STS_OK = 8'h00;
  localparam logic [7:0] STS_UNSUPPORTED = 8'h01;
  localparam logic [7:0] STS_LOCKED = 8'h02;
  // chip settings payload, byte offsets from byte 2
  localparam int OFS_B2 = 0;
  localparam int OFS_B3 = 1;
  localparam int OFS_B4 = 2;
  localparam int OFS_B5 = 3;
  localparam int OFS_VID_LO = 4;
  localparam int OFS_VID_HI = 5;
  localparam int OFS_PID_LO = 6;
  localparam int OFS_PID_HI = 7;
  localparam int OFS_PWR = 8;
  localparam int OFS_CUR = 9;
  localparam int OFS_PW = 10;
  localparam int PW_BYTES = 8;
  // field positions
  localparam int POS_CDC_SER = 7;
  localparam int POS_SEC_LO = 0;
  localparam int POS_CLKDIV_LO = 0;
  localparam int POS_DAC_LVL_LO = 6;
  localparam int POS_DAC_SUP = 5;
  localparam int POS_DAC_VAL_LO = 0;
  localparam int POS_INT_NEG = 6;
  localparam int POS_INT_POS = 5;
  localparam int POS_ADC_LVL_LO = 3;
  localparam int POS_ADC_INT = 2;
  // reset values of the stored settings
  localparam logic [1:0] RST_SEC = 2'h0;
  localparam logic [4:0] RST_CLKDIV = 5'h00;
  localparam logic [1:0] RST_VREF_LVL = 2'h0;
  localparam logic [4:0] RST_DAC_VAL = 5'h00;
  localparam logic [7:0] RST_PWR = 8'h80;
  localparam logic [7:0] RST_CUR = 8'h32;
  // flash write targets
  typedef enum logic [2:0] {
    FSWC_TGT_CHIP, FSWC_TGT_GENPIN, FSWC_TGT_MFR, FSWC_TGT_PROD,
    FSWC_TGT_SER, FSWC_TGT_NONE
  } fswc_target_t;
endpackage

//--- rtl/fswc_edge_det.sv
// Purpose: interrupt pin edge detection with sticky flag
// Assumes: pin is asynchronous to sys_clk_in
// Notes: set wins over a clear in the same cycle
`timescale 1ns/100ps
module fswc_edge_det (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // pin and controls
  input wire logic int_pin_in,
  input wire logic neg_en_in,
  input wire logic pos_en_in,
  input wire logic flag_clr_in,
  // status
  output logic flag_out
);
  logic s1_q, s2_q, s3_q;
  logic flag_q, flag_d;
  wire rise = s2_q & ~s3_q;
  wire fall = ~s2_q & s3_q;
  // either edge may set the flag, both enables may be on together
  wire set_ev = (rise & pos_en_in) | (fall & neg_en_in);

  // three stage synchroniser, first stage read only by the second
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= int_pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // sticky flag; an edge in the clear cycle is kept
  assign flag_d = set_ev | (flag_q & ~flag_clr_in);
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) flag_q <= 1'b0;
    else flag_q <= flag_d;
  end
  assign flag_out = flag_q;

  a_flag_on_fall: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (fall && neg_en_in) |=> flag_out) else $error("fall edge lost");
  a_flag_on_rise: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (rise && pos_en_in) |=> flag_out) else $error("rise edge lost");
  a_flag_no_cause: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    $rose(flag_out) |-> $past(set_ev)) else $error("flag set w/o edge");
endmodule

//--- rtl/fswc_decoder.sv
// Purpose: decoder for the nonvolatile settings write report
// Assumes: report bytes arrive one per valid cycle, sop on byte 0
// Notes: chip settings are staged and committed only after byte 63
// Operation
// - byte 0 of 0xB1 marks a nonvolatile settings write request
// - sub-code 0x00 selects chip settings, 0x01 general pin settings
// - sub-codes 0x02..0x04 store manufacturer, product, serial strings
// - unknown sub-code: no write, unsupported status in response byte 1
// - bytes 2 to 63 are payload laid out by the sub-code
// - byte 2 bit 7 enables serial-number descriptor for CDC
// - byte 2 bits 1-0 select lock, password or unsecured mode
// - byte 3 bits 4-0 hold clock output divider code
// - byte 4 bits 7-6 select DAC internal reference level or off
// - byte 4 bit 5: 1 supply rail, 0 internal reference module
// - byte 4 bits 4-0 hold the power-up DAC value
// - byte 5 bit 6 enables falling-edge interrupt detection
// - byte 5 bit 5 enables rising-edge detection, both may be on
// - byte 5 bits 4-3 select ADC internal reference level or off
// - byte 5 bit 2: 1 internal reference module, 0 supply rail
// - bytes 6 and 7 hold vendor ID, low byte first
// - bytes 8 and 9 hold product ID, low byte first
// - byte 10 power attributes, byte 11 current, reported doubled
// - bytes 12-19 hold the 8-byte password, 20-63 ignored
`timescale 1ns/100ps
module fswc_decoder
  import fswc_pkg::*;
#(
  parameter logic [15:0] VID_RST = 16'h1234, // arbitrary value
  parameter logic [15:0] PID_RST = 16'h5678, // arbitrary value
  parameter int REPORT_BYTES = RPT_LEN
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // report byte stream from the host
  input wire logic rx_valid_in,
  input wire logic rx_sop_in,
  input wire logic [7:0] rx_data_in,
  // response report
  output logic resp_valid_out,
  output logic [7:0] resp_cmd_out,
  output logic [7:0] resp_status_out,
  // flash byte write port for pin settings and strings
  output logic fw_valid_out,
  output logic [2:0] fw_target_out,
  output logic [5:0] fw_index_out,
  output logic [7:0] fw_data_out,
  // stored chip settings
  output logic chip_upd_out,
  output logic cdc_serial_en_out,
  output logic [1:0] security_mode_out,
  output logic [4:0] clkout_div_out,
  output logic [1:0] dac_vref_level_out,
  output logic dac_vref_supply_out,
  output logic [4:0] dac_pwrup_out,
  output logic int_neg_en_out,
  output logic int_pos_en_out,
  output logic [1:0] adc_vref_level_out,
  output logic adc_vref_internal_out,
  output logic [15:0] vid_out,
  output logic [15:0] pid_out,
  output logic [7:0] pwr_attr_out,
  output logic [7:0] cur_req_out,
  output logic [8:0] cur_ma_half_out,
  output logic [63:0] password_out,
  // interrupt detection
  input wire logic int_pin_in,
  input wire logic int_flag_clr_in,
  output logic int_flag_out
);

  initial begin
    if (REPORT_BYTES != RPT_LEN)
      $error("report length must be 64 bytes");
  end

  // map a sub-code to its flash target
  function automatic fswc_target_t sub_target(input logic [7:0] sub);
    case (sub)
      SUB_CHIP: sub_target = FSWC_TGT_CHIP;
      SUB_GENPIN: sub_target = FSWC_TGT_GENPIN;
      SUB_STR_MFR: sub_target = FSWC_TGT_MFR;
      SUB_STR_PROD: sub_target = FSWC_TGT_PROD;
      SUB_STR_SER: sub_target = FSWC_TGT_SER;
      default: sub_target = FSWC_TGT_NONE;
    endcase
  endfunction

  // frame tracking
  logic [5:0] idx_q, idx_d;
  logic in_frame_q, in_frame_d;
  logic [7:0] cmd_q;
  logic [7:0] sub_q;
  logic [7:0] stage_q [0:CHIP_BYTES-1];

  // the current byte's position; sop always restarts at byte 0
  wire [5:0] cur_idx = rx_sop_in ? IDX_CMD : idx_q;
  wire byte_ok = rx_valid_in & (rx_sop_in | in_frame_q);
  wire at_cmd = byte_ok & (cur_idx == IDX_CMD);
  wire at_sub = byte_ok & (cur_idx == IDX_SUB);
  wire at_pay = byte_ok & (cur_idx >= IDX_PAY_FIRST);
  wire at_last = byte_ok & (cur_idx == IDX_LAST);
  wire is_write = (cmd_q == CMD_WRITE_NV);
  wire fswc_target_t tgt = sub_target(sub_q);
  // a permanently locked part refuses all further stores
  wire locked = security_mode_out[1];
  wire may_write = is_write & (tgt != FSWC_TGT_NONE) & ~locked;

  // index counter and frame flag
  assign in_frame_d = byte_ok ? ~at_last : in_frame_q;
  assign idx_d = byte_ok ? cur_idx + 6'h01 : idx_q;
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      idx_q <= 6'h00;
      in_frame_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      in_frame_q <= in_frame_d;
    end
  end

  // header bytes
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      cmd_q <= 8'h00;
      sub_q <= 8'h00;
    end else begin
      if (at_cmd) cmd_q <= rx_data_in;
      if (at_sub) sub_q <= rx_data_in;
    end
  end

  // chip payload staging; bytes past 19 are never kept
  wire stage_we = at_pay & (cur_idx <= IDX_CHIP_LAST) & is_write &
    (tgt == FSWC_TGT_CHIP);
  wire [5:0] stage_ptr = cur_idx - IDX_PAY_FIRST;
  always_ff @(posedge sys_clk_in) begin
    if (stage_we) stage_q[stage_ptr[4:0]] <= rx_data_in;
  end

  // byte write port; chip settings stay local and are not streamed
  wire fw_we = at_pay & may_write & (tgt != FSWC_TGT_CHIP);
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      fw_valid_out <= 1'b0;
      fw_target_out <= 3'h0;
      fw_index_out <= 6'h00;
      fw_data_out <= 8'h00;
    end else begin
      fw_valid_out <= fw_we;
      if (fw_we) begin
        fw_target_out <= tgt;
        fw_index_out <= cur_idx;
        fw_data_out <= rx_data_in;
      end
    end
  end

  // response status; unsupported wins over locked
  wire [7:0] status = (tgt == FSWC_TGT_NONE) ? STS_UNSUPPORTED :
    (locked ? STS_LOCKED : STS_OK);
  wire resp_fire = at_last & is_write;
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      resp_valid_out <= 1'b0;
      resp_cmd_out <= 8'h00;
      resp_status_out <= 8'h00;
    end else begin
      resp_valid_out <= resp_fire;
      if (resp_fire) begin
        resp_cmd_out <= cmd_q;
        resp_status_out <= status;
      end
    end
  end

  // commit after the whole report so a cut-off report changes nothing
  wire commit = at_last & may_write & (tgt == FSWC_TGT_CHIP);
  logic [7:0] b2, b3, b4, b5;
  assign b2 = stage_q[OFS_B2];
  assign b3 = stage_q[OFS_B3];
  assign b4 = stage_q[OFS_B4];
  assign b5 = stage_q[OFS_B5];
  logic [63:0] pw_word;
  always_comb begin
    pw_word = 64'h0;
    for (int i = 0; i < PW_BYTES; i++)
      pw_word[i*8 +: 8] = stage_q[OFS_PW + i];
  end

  // only named bits are taken, others are don't care
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      chip_upd_out <= 1'b0;
      cdc_serial_en_out <= 1'b0;
      security_mode_out <= RST_SEC;
      clkout_div_out <= RST_CLKDIV;
      dac_vref_level_out <= RST_VREF_LVL;
      dac_vref_supply_out <= 1'b0;
      dac_pwrup_out <= RST_DAC_VAL;
      int_neg_en_out <= 1'b0;
      int_pos_en_out <= 1'b0;
      adc_vref_level_out <= RST_VREF_LVL;
      adc_vref_internal_out <= 1'b0;
      vid_out <= VID_RST;
      pid_out <= PID_RST;
      pwr_attr_out <= RST_PWR;
      cur_req_out <= RST_CUR;
      password_out <= 64'h0;
    end else begin
      chip_upd_out <= commit;
      if (commit) begin
        cdc_serial_en_out <= b2[POS_CDC_SER];
        security_mode_out <= b2[POS_SEC_LO +: 2];
        clkout_div_out <= b3[POS_CLKDIV_LO +: 5];
        dac_vref_level_out <= b4[POS_DAC_LVL_LO +: 2];
        dac_vref_supply_out <= b4[POS_DAC_SUP];
        dac_pwrup_out <= b4[POS_DAC_VAL_LO +: 5];
        int_neg_en_out <= b5[POS_INT_NEG];
        int_pos_en_out <= b5[POS_INT_POS];
        adc_vref_level_out <= b5[POS_ADC_LVL_LO +: 2];
        adc_vref_internal_out <= b5[POS_ADC_INT];
        vid_out <= {stage_q[OFS_VID_HI], stage_q[OFS_VID_LO]};
        pid_out <= {stage_q[OFS_PID_HI], stage_q[OFS_PID_LO]};
        pwr_attr_out <= stage_q[OFS_PWR];
        cur_req_out <= stage_q[OFS_CUR];
        password_out <= pw_word;
      end
    end
  end

  // requested current in mA is the stored value doubled
  assign cur_ma_half_out = {cur_req_out, 1'b0};

  // edge detection runs from the stored enables
  fswc_edge_det u_edge (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .int_pin_in(int_pin_in),
    .neg_en_in(int_neg_en_out),
    .pos_en_in(int_pos_en_out),
    .flag_clr_in(int_flag_clr_in),
    .flag_out(int_flag_out)
  );

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  a_resp_echo_code: assert property (resp_valid_out |->
    resp_cmd_out == CMD_WRITE_NV) else $error("bad echo");
  a_resp_follows_last: assert property ((at_last && is_write) |=>
    resp_valid_out ##1 !resp_valid_out) else $error("no response");
  a_unsup_no_write: assert property ((at_pay && is_write &&
    tgt == FSWC_TGT_NONE) |=> !fw_valid_out) else $error("bad write");
  a_unsup_status: assert property ((at_last && is_write &&
    tgt == FSWC_TGT_NONE) |=> resp_status_out == STS_UNSUPPORTED &&
    !chip_upd_out) else $error("unsupported not flagged");
  a_fw_payload_only: assert property (fw_valid_out |->
    fw_index_out >= IDX_PAY_FIRST && fw_target_out != FSWC_TGT_CHIP)
    else $error("write outside payload");
  a_vid_only_commit: assert property (!$stable(vid_out) |->
    chip_upd_out) else $error("vid moved w/o commit");
  a_chip_ok_status: assert property (chip_upd_out |->
    resp_valid_out && resp_status_out == STS_OK)
    else $error("commit w/o ok");
  a_cdc_bit_taken: assert property (chip_upd_out |->
    cdc_serial_en_out == $past(b2[POS_CDC_SER]) &&
    dac_vref_supply_out == $past(b4[POS_DAC_SUP]))
    else $error("bits misplaced");
  a_lock_blocks_fw: assert property (locked |=> !fw_valid_out)
    else $error("write while locked");
endmodule

//--- verification/fswc_host_model.sv
// Purpose: host side model sending 64-byte command reports
// Assumes: one byte per valid cycle, sop marks byte 0
// Notes: gap gives idle cycles after each byte
`timescale 1ns/100ps
module fswc_host_model (
  // clock
  input wire logic sys_clk_in,
  // report stream
  output logic rx_valid_out,
  output logic rx_sop_out,
  output logic [7:0] rx_data_out
);
  initial begin
    rx_valid_out = 1'b0;
    rx_sop_out = 1'b0;
    rx_data_out = 8'h5A;
  end
  // idle data is inverted so a stale byte never passes for fresh
  task automatic send(input logic [7:0] r [0:63], input int gap);
    for (int i = 0; i < 64; i++) begin
      @(posedge sys_clk_in);
      rx_valid_out <= 1'b1;
      rx_sop_out <= (i == 0);
      rx_data_out <= r[i];
      for (int g = 0; g < gap; g++) begin
        @(posedge sys_clk_in);
        rx_valid_out <= 1'b0;
        rx_sop_out <= 1'b0;
        rx_data_out <= ~r[i];
      end
    end
    @(posedge sys_clk_in);
    rx_valid_out <= 1'b0;
    rx_sop_out <= 1'b0;
    rx_data_out <= ~r[63];
  endtask
endmodule

//--- verification/tb_flash_settings_write_command.sv
// Purpose: self-checking bench for the settings write decoder
// Assumes: responses and writes are single-cycle pulses
// Notes: lock test runs last since the lock stays until reset
`timescale 1ns/100ps
module tb_flash_settings_write_command
  import fswc_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic pin = 1'b1;
  logic clr = 1'b0;
  logic rx_valid, rx_sop, resp_valid, fw_valid, chip_upd, cdc, dsup;
  logic neg, pos, aint, flag;
  logic [7:0] rx_data, rcmd, rsts, fw_data, pwr, cur, last_cmd, last_sts;
  logic [2:0] fw_tgt;
  logic [5:0] fw_idx;
  logic [1:0] sec, dlvl, alvl;
  logic [4:0] cdiv, dval;
  logic [15:0] vid, pid;
  logic [8:0] mah;
  logic [63:0] pw;
  logic [7:0] rpt [0:63];
  logic [7:0] bad [3] = '{8'h05, 8'h80, 8'hFF};
  int fail_count = 0;
  int checks = 0;
  int n_resp = 0;
  int n_chip = 0;
  int n_fw = 0;
  int cyc = 0;

  always #12.5 sys_clk_in = ~sys_clk_in;

  fswc_host_model host (.sys_clk_in(sys_clk_in), .rx_valid_out(rx_valid),
    .rx_sop_out(rx_sop), .rx_data_out(rx_data));

  fswc_decoder DUT (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .rx_valid_in(rx_valid), .rx_sop_in(rx_sop), .rx_data_in(rx_data),
    .resp_valid_out(resp_valid), .resp_cmd_out(rcmd),
    .resp_status_out(rsts), .fw_valid_out(fw_valid),
    .fw_target_out(fw_tgt), .fw_index_out(fw_idx), .fw_data_out(fw_data),
    .chip_upd_out(chip_upd), .cdc_serial_en_out(cdc),
    .security_mode_out(sec), .clkout_div_out(cdiv),
    .dac_vref_level_out(dlvl), .dac_vref_supply_out(dsup),
    .dac_pwrup_out(dval), .int_neg_en_out(neg), .int_pos_en_out(pos),
    .adc_vref_level_out(alvl), .adc_vref_internal_out(aint),
    .vid_out(vid), .pid_out(pid), .pwr_attr_out(pwr), .cur_req_out(cur),
    .cur_ma_half_out(mah), .password_out(pw), .int_pin_in(pin),
    .int_flag_clr_in(clr), .int_flag_out(flag));

  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // pulses are counted one edge after they rise, when settled
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (resp_valid === 1'b1) begin
      n_resp++;
      last_cmd = rcmd;
      last_sts = rsts;
    end
    if (chip_upd === 1'b1)
      n_chip++;
    if (fw_valid === 1'b1) begin
      n_fw++;
      chk({fw_tgt, fw_data}, {rpt[1][2:0], rpt[fw_idx]});
    end
    if (cyc >= 20000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic fill(input logic [7:0] cmd, input logic [7:0] sub);
    rpt[0] = cmd;
    rpt[1] = sub;
    for (int k = 2; k < 64; k++)
      rpt[k] = 8'(k) ^ {sub[2:0], 5'h00};
  endtask

  // send rpt, then compare pulse counts and the response
  task automatic xfer(input int gap, input logic [7:0] sts,
                      input int nr, input int nc, input int nf);
    int r0, c0, f0;
    r0 = n_resp;
    c0 = n_chip;
    f0 = n_fw;
    host.send(rpt, gap);
    repeat (3) @(posedge sys_clk_in);
    chk(64'(n_resp - r0), 64'(nr));
    chk(64'(n_chip - c0), 64'(nc));
    chk(64'(n_fw - f0), 64'(nf));
    if (nr != 0)
      chk({last_cmd, last_sts}, {CMD_WRITE_NV, sts});
  endtask

  // expected fields taken straight from the report bytes
  task automatic chk_chip();
    chk({cdc, sec, cdiv, dlvl, dsup, dval, neg, pos, alvl, aint},
      {rpt[2][7], rpt[2][1:0], rpt[3][4:0], rpt[4], rpt[5][6:2]});
    chk({vid, pid}, {rpt[7], rpt[6], rpt[9], rpt[8]});
    chk({pwr, cur, mah}, {rpt[10], rpt[11], rpt[11], 1'b0});
    chk(pw, {rpt[19], rpt[18], rpt[17], rpt[16],
      rpt[15], rpt[14], rpt[13], rpt[12]});
  endtask

  // falling then rising pin edge, flag cleared before each
  task automatic edge_chk(input logic en_neg, input logic en_pos);
    for (int p = 0; p < 2; p++) begin
      clr <= 1'b1;
      @(posedge sys_clk_in);
      clr <= 1'b0;
      pin <= p[0];
      repeat (6) @(posedge sys_clk_in);
      chk(64'(flag), 64'(p[0] ? en_pos : en_neg));
    end
  endtask

  initial begin
    repeat (5) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    chk({sec, cdiv, dlvl, dval, vid, pid, pwr, cur, flag},
      {RST_SEC, RST_CLKDIV, RST_VREF_LVL, RST_DAC_VAL, 16'h1234,
       16'h5678, RST_PWR, RST_CUR, 1'b0});
    for (int i = 0; i < 4; i++) begin
      fill(CMD_WRITE_NV, SUB_CHIP);
      rpt[2] = {i[0], 5'h1F, 1'b0, i[0]};
      rpt[3] = {3'h7, 5'(i * 7 + 3)};
      rpt[4] = {i[1:0], ~i[0], 5'(i * 9 + 1)};
      rpt[5] = {1'b1, i[1], i[0], i[1:0], ~i[1], 2'h3};
      rpt[6] = 8'hC0 + 8'(i);
      xfer(i, STS_OK, 1, 1, 0);
      chk_chip();
      edge_chk(i[1], i[0]);
    end
    for (int s = 1; s < 5; s++) begin
      fill(CMD_WRITE_NV, 8'(s));
      xfer(s - 1, STS_OK, 1, 0, 62);
    end
    foreach (bad[j]) begin
      fill(CMD_WRITE_NV, bad[j]);
      xfer(0, STS_UNSUPPORTED, 1, 0, 0);
    end
    fill(8'hB0, SUB_CHIP);
    xfer(0, STS_OK, 0, 0, 0);
    fill(CMD_WRITE_NV, SUB_CHIP);
    rpt[2] = 8'h03;
    xfer(0, STS_OK, 1, 1, 0);
    rpt[2] = 8'h81;
    rpt[11] = 8'hEE;
    xfer(0, STS_LOCKED, 1, 0, 0);
    rpt[2] = 8'h03;
    rpt[11] = 8'h0B;
    chk_chip();
    fill(CMD_WRITE_NV, SUB_GENPIN);
    xfer(0, STS_LOCKED, 1, 0, 0);
    fill(CMD_WRITE_NV, 8'h09);
    xfer(0, STS_UNSUPPORTED, 1, 0, 0);
    close_out();
  end
endmodule
